// *** rtl/sscr_pkg.sv ***
// constants shared by the serial command block of the quad lamp switch
// assumes one 20 MHz system clock; serial pins are asynchronous to it
//
// Functional notes
// - frames are sixteen bits, msb first
// - bits 14:13 pick one of four outputs
// - bits 12:10 are the register address
// - low nine bits are the register payload
// - only whole multiples of sixteen bits latch
// - every reset source clears all register bits
// - low on-current sets openload flag, output stays
// - led mode checks once per interval, full duty
// - openload flag held until gone and read
// - per-output bit disables on-openload detection
// - sense routing from config; mirror off in fail-safe
// - prewarning flag latched, cleared by read
// - clamp trip forces all outputs on
// - logic supply fail with enable clears registers
// - no logic supply: outputs follow direct inputs
// - battery loss keeps config, reports undervoltage
// - both supplies lost clear registers and faults
// - status payload low five bits pick readback
// - duty register bit seven sets output state
package sscr_pkg;
  localparam int FRAME_W = 16; // bits in one frame
  localparam int PAY_W = 9; // payload width
  localparam int NOUT = 4; // switch outputs
  localparam int WD_BIT = 15; // watchdog toggle bit
  localparam int SEL_HI = 14; // output select field
  localparam int SEL_LO = 13;
  localparam int ADR_HI = 12; // register address field
  localparam int ADR_LO = 10;
  // register addresses
  localparam logic [2:0] ADR_STAT = 3'h0;
  localparam logic [2:0] ADR_DUTY = 3'h1;
  localparam logic [2:0] ADR_SWC = 3'h2;
  localparam logic [2:0] ADR_FLT = 3'h3;
  localparam logic [2:0] ADR_OC = 3'h4;
  localparam logic [2:0] ADR_GCR = 3'h5;
  localparam logic [2:0] ADR_CAL = 3'h7;
  localparam logic [8:0] CAL_PATTERN = 9'h15B; // fixed calibration payload
  localparam logic [8:0] REG_RST = 9'h000; // value of every register after reset
  // field positions
  localparam int DUTY_ON = 7; // output on command
  localparam logic [7:0] DUTY_FULL = 8'hFF; // on bit plus full duty code
  localparam int SWC_DIR_DIS = 5; // direct input disable
  localparam int FLT_ON_OPENLOAD_FLAG_DIS = 3; // on-openload disable
  localparam int FLT_LED = 1; // led openload select
  localparam int FLT_RATIO = 0; // sense ratio select
  localparam int GCR_VDDF_EN = 8; // logic supply fail enable
  localparam int GCR_PWM_EN = 7; // pwm module enable
  localparam int GCR_TEMP_EN = 5; // temperature sense enable
  localparam int GCR_SNS_EN = 4; // sense output enable
  localparam int GCR_CH_HI = 3; // sense channel select
  localparam int GCR_CH_LO = 2;
  localparam int STAT_SEL_W = 5; // readback select width
  // timing
  localparam int CLK_KHZ = 20000; // system clock rate
  localparam int LED_CHECK_US = 20000; // led check interval, microseconds
  localparam int LED_CHECK_CYC = LED_CHECK_US / 1000 * CLK_KHZ;
endpackage

// *** rtl/sscr_frame_if.sv ***
// bundle between the serial shifter and the register core
// assumes both ends share one clock
`timescale 1ns/1ns
interface sscr_frame_if;
  logic load; // pulse: chip select fell, readback captured
  logic done; // pulse: chip select rose
  logic ok; // with done: length was a whole multiple
  logic [15:0] data; // last sixteen bits shifted in
  logic [15:0] so_word; // readback word to send next
  logic so; // serial out bit
  logic so_oe_n; // serial out enable, low drives
  modport shifter (output load, done, ok, data, so, so_oe_n, input so_word);
  modport core (input load, done, ok, data, so, so_oe_n, output so_word);
endinterface

// *** rtl/sscr_sync.sv ***
// two-flop synchroniser for a vector of unrelated levels
// assumes each bit is a slow level or the 400 ns serial clock
`timescale 1ns/1ns
module sscr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  // two stages, cleared by reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// *** rtl/sscr_frame.sv ***
// serial shifter: counts bits, shifts in and out for daisy chains
// assumes synchronised pins; samples on the rising serial clock
`timescale 1ns/1ns
module sscr_frame
  import sscr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  sscr_frame_if.shifter fr
);
  logic sclk_p_q; // previous serial clock
  logic cs_p_q; // previous chip select
  logic [15:0] shift_q; // in and out shift register
  logic [3:0] cnt_q; // bit count modulo sixteen
  logic any_q; // at least one bit this frame
  logic rise;
  logic cs_fall;
  logic cs_rise;
  assign rise = sclk_i & ~sclk_p_q & ~cs_n_i;
  assign cs_fall = cs_p_q & ~cs_n_i;
  assign cs_rise = ~cs_p_q & cs_n_i;
  // edge history
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_i;
      cs_p_q <= cs_n_i;
    end
  end
  // load readback, then shift msb first so old bits pass on
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_q <= 16'h0000;
      cnt_q <= 4'h0;
      any_q <= 1'b0;
    end else if (cs_fall) begin
      shift_q <= fr.so_word;
      cnt_q <= 4'h0;
      any_q <= 1'b0;
    end else if (rise) begin
      shift_q <= {shift_q[14:0], si_i};
      cnt_q <= cnt_q + 4'h1;
      any_q <= 1'b1;
    end
  end
  // strobes and serial out
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fr.load <= 1'b0;
      fr.done <= 1'b0;
      fr.ok <= 1'b0;
      fr.so_oe_n <= 1'b1;
    end else begin
      fr.load <= cs_fall;
      fr.done <= cs_rise;
      fr.ok <= cs_rise & any_q & (cnt_q == 4'h0);
      fr.so_oe_n <= cs_n_i;
    end
  end
  assign fr.data = shift_q;
  assign fr.so = shift_q[15];
endmodule

// *** rtl/sscr_core.sv ***
// register core of the quad switch serial command block
// assumes comparator and supply monitor levels arrive as pins
`timescale 1ns/1ns
module sscr_core
  import sscr_pkg::*;
#(
  parameter int unsigned LED_CHECK_CYCLES = LED_CHECK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_sclk_i, // serial clock from host
  input wire logic spi_cs_n_i, // chip select, low active
  input wire logic spi_si_i, // serial in
  output logic spi_so_o, // serial out
  output logic spi_so_oe_n_o, // serial out enable, low drives
  input wire logic rst_pin_n_i, // reset pin, low clears
  input wire logic vdd_fail_i, // logic supply below fail level
  input wire logic por_i, // both supplies below power-on level
  input wire logic vpwr_uv_i, // battery undervoltage
  input wire logic clamp_trip_i, // battery clamp comparator
  input wire logic otw_cmp_i, // prewarning comparator
  input wire logic [3:0] overload_i, // pending overload turn-off
  input wire logic [3:0] dir_in_i, // direct input pins
  input wire logic [3:0] ol_cmp_i, // on-current below threshold
  output logic [3:0] switch_outputs_o, // gate commands
  output logic [3:0] on_openload_flag_o, // latched openload
  output logic thermal_prewarning_flag_o, // latched prewarning
  output logic undervoltage_flag_o, // latched undervoltage
  output logic [3:0] led_openload_select_o, // led threshold per output
  output logic sense_mirror_en_o, // current mirror on
  output logic sense_temp_en_o, // temperature on sense pin
  output logic [1:0] sense_channel_select_o, // mirrored output
  output logic sense_ratio_select_o // high ratio
);
  localparam int ITV_W = $clog2(LED_CHECK_CYCLES + 1);

  //////////////////////////////////////////////////////////////////
  // pin synchronisers and shifter

  logic sclk_s, cs_sel_s, si_s, rst_act_s, vdd_fail_s, por_s, uv_s, clamp_s, otw_s;
  logic [3:0] ovl_s, dir_s, olc_s;
  sscr_frame_if fr ();

  // every pin passes two flops; low-active pins enter inverted so reset matches idle
  sscr_sync #(.W(21)) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({spi_sclk_i, ~spi_cs_n_i, spi_si_i, ~rst_pin_n_i, vdd_fail_i, por_i, vpwr_uv_i,
          clamp_trip_i, otw_cmp_i, overload_i, dir_in_i, ol_cmp_i}),
    .q_o({sclk_s, cs_sel_s, si_s, rst_act_s, vdd_fail_s, por_s, uv_s,
          clamp_s, otw_s, ovl_s, dir_s, olc_s})
  );

  // serial shifter
  sscr_frame u_frame (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_s),
    .cs_n_i(~cs_sel_s),
    .si_i(si_s),
    .fr(fr)
  );

  //////////////////////////////////////////////////////////////////
  // command registers

  logic [8:0] duty_q [NOUT]; // per-output duty and on command
  logic [8:0] swc_q [NOUT]; // per-output switching config
  logic [8:0] flt_q [NOUT]; // per-output fault config
  logic [8:0] oc_q [NOUT]; // per-output overcurrent config
  logic [8:0] gcr_q; // global config
  logic [4:0] stat_sel_q; // readback select
  logic cal_seen_q; // calibration command accepted
  logic wd_q; // last watchdog toggle bit
  logic [1:0] f_out; // output select of frame
  logic [2:0] f_adr; // address of frame
  logic [8:0] f_pay; // payload of frame
  logic wr; // valid frame applies this cycle
  logic clr_all; // register clear from reset pin or supplies
  logic failsafe; // no logic supply

  assign f_out = fr.data[SEL_HI:SEL_LO];
  assign f_adr = fr.data[ADR_HI:ADR_LO];
  assign f_pay = fr.data[PAY_W-1:0];
  assign wr = fr.done & fr.ok;
  assign failsafe = vdd_fail_s;
  // reset pin, supply fail with enable, or power-on level
  assign clr_all = rst_act_s | (vdd_fail_s & gcr_q[GCR_VDDF_EN]) | por_s;

  // register writes; battery loss does not touch them
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NOUT; i++) begin
        duty_q[i] <= REG_RST;
        swc_q[i] <= REG_RST;
        flt_q[i] <= REG_RST;
        oc_q[i] <= REG_RST;
      end
      gcr_q <= REG_RST;
      stat_sel_q <= 5'h00;
      wd_q <= 1'b0;
    end else if (clr_all) begin
      // all bits go to zero
      for (int i = 0; i < NOUT; i++) begin
        duty_q[i] <= REG_RST;
        swc_q[i] <= REG_RST;
        flt_q[i] <= REG_RST;
        oc_q[i] <= REG_RST;
      end
      gcr_q <= REG_RST;
      stat_sel_q <= 5'h00;
      wd_q <= 1'b0;
    end else if (wr) begin
      wd_q <= fr.data[WD_BIT];
      case (f_adr)
        ADR_STAT: stat_sel_q <= f_pay[STAT_SEL_W-1:0];
        ADR_DUTY: duty_q[f_out] <= f_pay;
        ADR_SWC: swc_q[f_out] <= f_pay;
        ADR_FLT: flt_q[f_out] <= f_pay;
        ADR_OC: oc_q[f_out] <= f_pay;
        ADR_GCR: gcr_q <= f_pay;
        default: begin
          // calibration carries no stored state here
        end
      endcase
    end
  end

  // calibration is taken only with its fixed payload
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_seen_q <= 1'b0;
    end else if (clr_all) begin
      cal_seen_q <= 1'b0;
    end else if (wr && f_adr == ADR_CAL && f_pay == CAL_PATTERN) begin
      cal_seen_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////
  // readback word and clear on read

  logic [15:0] so_word; // word loaded at chip select fall
  logic [1:0] rb_out; // output picked for readback
  logic [8:0] rb_pay; // payload picked for readback
  logic shown_q; // status word went out this frame
  logic rd_clr; // status read finished

  assign rb_out = stat_sel_q[4:3];
  // pick status or a register image
  always_comb begin
    rb_pay = REG_RST;
    case (stat_sel_q[2:0])
      ADR_DUTY: rb_pay = duty_q[rb_out];
      ADR_SWC: rb_pay = swc_q[rb_out];
      ADR_FLT: rb_pay = flt_q[rb_out];
      ADR_OC: rb_pay = oc_q[rb_out];
      ADR_GCR: rb_pay = gcr_q;
      ADR_CAL: rb_pay = cal_seen_q ? CAL_PATTERN : REG_RST;
      default: rb_pay = REG_RST;
    endcase
    if (stat_sel_q == 5'h00) begin
      so_word = {wd_q, 6'h00, cal_seen_q, thermal_prewarning_flag_o, undervoltage_flag_o,
                 2'h0, on_openload_flag_o};
    end else begin
      so_word = {wd_q, rb_out, stat_sel_q[2:0], 1'b0, rb_pay};
    end
  end
  assign fr.so_word = so_word;

  // remember that the status word is on its way out
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shown_q <= 1'b0;
    end else if (fr.load) begin
      shown_q <= (stat_sel_q == 5'h00);
    end else if (fr.done) begin
      shown_q <= 1'b0;
    end
  end
  assign rd_clr = wr & shown_q;

  //////////////////////////////////////////////////////////////////
  // output switches

  logic [3:0] sw_d; // next gate command
  // direct inputs without logic supply, clamp forces all on
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      if (failsafe) begin
        sw_d[i] = dir_s[i];
      end else begin
        sw_d[i] = duty_q[i][DUTY_ON] | (dir_s[i] & ~swc_q[i][SWC_DIR_DIS]);
      end
      sw_d[i] = sw_d[i] & ~ovl_s[i] & ~uv_s;
      if (clamp_s) begin
        sw_d[i] = 1'b1;
      end
    end
  end

  // gate command flops
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      switch_outputs_o <= 4'h0;
    end else begin
      switch_outputs_o <= sw_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // on-openload detection

  logic [ITV_W-1:0] itv_cnt_q; // led check interval counter
  logic tick; // interval boundary
  logic [3:0] armed_q; // output on at full duty since an interval boundary
  logic [3:0] full; // on at full duty with pwm enabled
  logic [3:0] ol_set; // openload seen this cycle

  assign tick = (itv_cnt_q == ITV_W'(LED_CHECK_CYCLES - 1));
  // free running interval
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      itv_cnt_q <= '0;
    end else if (tick) begin
      itv_cnt_q <= '0;
    end else begin
      itv_cnt_q <= itv_cnt_q + ITV_W'(1);
    end
  end

  // per-output set conditions
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      full[i] = (duty_q[i][7:0] == DUTY_FULL) & gcr_q[GCR_PWM_EN];
      if (flt_q[i][FLT_ON_OPENLOAD_FLAG_DIS] || failsafe) begin
        ol_set[i] = 1'b0;
      end else if (flt_q[i][FLT_LED]) begin
        ol_set[i] = tick & armed_q[i] & full[i] & olc_s[i];
      end else begin
        ol_set[i] = switch_outputs_o[i] & olc_s[i];
      end
    end
  end

  // arm at an interval boundary while on at full duty, set wins over read clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed_q <= 4'h0;
      on_openload_flag_o <= 4'h0;
    end else if (clr_all) begin
      armed_q <= 4'h0;
      on_openload_flag_o <= 4'h0;
    end else begin
      for (int i = 0; i < NOUT; i++) begin
        if (!switch_outputs_o[i] || !full[i]) begin
          armed_q[i] <= 1'b0;
        end else if (tick) begin
          armed_q[i] <= 1'b1;
        end
        if (ol_set[i]) begin
          on_openload_flag_o[i] <= 1'b1;
        end else if (rd_clr && !olc_s[i]) begin
          on_openload_flag_o[i] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // prewarning and undervoltage flags

  // latched in normal mode, cleared by a status read
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      thermal_prewarning_flag_o <= 1'b0;
      undervoltage_flag_o <= 1'b0;
    end else if (clr_all) begin
      thermal_prewarning_flag_o <= 1'b0;
      undervoltage_flag_o <= 1'b0;
    end else begin
      if (otw_s && !failsafe) begin
        thermal_prewarning_flag_o <= 1'b1;
      end else if (rd_clr) begin
        thermal_prewarning_flag_o <= 1'b0;
      end
      if (uv_s) begin
        undervoltage_flag_o <= 1'b1;
      end else if (rd_clr) begin
        undervoltage_flag_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // sense routing and config images

  // no mirror current without logic supply
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sense_mirror_en_o <= 1'b0;
      sense_temp_en_o <= 1'b0;
      sense_channel_select_o <= 2'h0;
      sense_ratio_select_o <= 1'b0;
      led_openload_select_o <= 4'h0;
    end else begin
      sense_mirror_en_o <= gcr_q[GCR_SNS_EN] & ~failsafe;
      sense_temp_en_o <= gcr_q[GCR_TEMP_EN];
      sense_channel_select_o <= gcr_q[GCR_CH_HI:GCR_CH_LO];
      sense_ratio_select_o <= flt_q[gcr_q[GCR_CH_HI:GCR_CH_LO]][FLT_RATIO];
      for (int i = 0; i < NOUT; i++) begin
        led_openload_select_o[i] <= flt_q[i][FLT_LED];
      end
    end
  end

  assign spi_so_o = fr.so;
  assign spi_so_oe_n_o = fr.so_oe_n;

  //////////////////////////////////////////////////////////////////
  // checks

  sequence s_bad_frame;
    fr.done && !fr.ok && !clr_all;
  endsequence
  sequence s_cal_write;
    wr && !clr_all && f_adr == ADR_CAL && f_pay == CAL_PATTERN;
  endsequence

  property p_short_frame;
    @(posedge clk_i) disable iff (sys_rst_i) s_bad_frame |=> $stable(gcr_q) && $stable(stat_sel_q);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame changed a register");

  property p_cal;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(cal_seen_q) |-> $past(wr && f_pay == CAL_PATTERN);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration taken with wrong payload");

  property p_cal_take;
    @(posedge clk_i) disable iff (sys_rst_i) s_cal_write |=> cal_seen_q;
  endproperty
  a_cal_take: assert property (p_cal_take) else $error("calibration pattern not taken");

  property p_clear;
    @(posedge clk_i) disable iff (sys_rst_i) clr_all |=> gcr_q == REG_RST && duty_q[0] == REG_RST
      && on_openload_flag_o == 4'h0 && !thermal_prewarning_flag_o;
  endproperty
  a_clear: assert property (p_clear) else $error("reset source left state behind");

  property p_ol_hold;
    @(posedge clk_i) disable iff (sys_rst_i) on_openload_flag_o[1] && olc_s[1] && !clr_all
      |=> on_openload_flag_o[1];
  endproperty
  a_ol_hold: assert property (p_ol_hold) else $error("openload flag dropped while present");

  property p_ol_dis;
    @(posedge clk_i) disable iff (sys_rst_i) !on_openload_flag_o[1] && flt_q[1][FLT_ON_OPENLOAD_FLAG_DIS]
      |=> !on_openload_flag_o[1];
  endproperty
  a_ol_dis: assert property (p_ol_dis) else $error("disabled openload flag set");

  property p_clamp;
    @(posedge clk_i) disable iff (sys_rst_i) clamp_s |=> switch_outputs_o == 4'hF;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp did not force outputs on");

  property p_failsafe;
    @(posedge clk_i) disable iff (sys_rst_i) failsafe && !clamp_s && !uv_s && ovl_s == 4'h0
      |=> switch_outputs_o == $past(dir_s);
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("outputs not following direct inputs");

  property p_otw;
    @(posedge clk_i) disable iff (sys_rst_i) otw_s && !failsafe && !clr_all ##1 !rd_clr && !clr_all
      |=> thermal_prewarning_flag_o;
  endproperty
  a_otw: assert property (p_otw) else $error("prewarning lost before read");

  property p_sense;
    @(posedge clk_i) disable iff (sys_rst_i) failsafe |=> !sense_mirror_en_o;
  endproperty
  a_sense: assert property (p_sense) else $error("mirror active in fail-safe");
endmodule

// *** tb/sscr_host_model.sv ***
// host-side serial master model for the switch command block
// assumes the bench clock paces it; pins change just after rising edges
`timescale 1ns/1ns
module sscr_host_model (
  input wire logic clk_i,
  output logic sclk_o, // serial clock, idles low
  output logic cs_n_o, // chip select, low active
  output logic si_o, // serial data to the device
  input wire logic so_i // serial data from the device
);
  logic [31:0] rx_q; // bits seen on serial out, last in lsb
  logic wd_q; // watchdog bit, flips every frame
  int half; // system clocks per half serial period
  // idle pins at time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rx_q = '0;
    wd_q = 1'b0;
    half = 4;
  end
  ////////////////////////////////////////////////////////////////
  // one chip select window of n bits, msb first
  task automatic xfer(input logic [31:0] w, input int n);
    w[9] = 1'b0;
    w[n - 1] = wd_q;
    wd_q = ~wd_q;
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (half) @(posedge clk_i);
      sclk_o <= 1'b0;
      si_o <= w[i];
      repeat (half) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx_q <= {rx_q[30:0], so_i};
    end
    repeat (half) @(posedge clk_i);
    sclk_o <= 1'b0;
    repeat (half) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // released data line shows the inverse of its last bit
    si_o <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// *** tb/switch_spi_command_registers_tb_top.sv ***
// self-checking bench for the switch serial command register core
// assumes the host model drives the serial pins; bench drives the rest
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module switch_spi_command_registers_tb_top;
  import sscr_pkg::*;
  logic clk_i, sys_rst_i, sclk, cs_n, si, so, so_oe_n; // clock, reset, link pins
  logic rst_pin_n_i, vdd_fail_i, por_i, clamp_trip_i, otw_cmp_i, vpwr_uv_i; // supply and comparator levels
  logic [3:0] dir_in_i, ol_cmp_i, overload_i, switch_outputs_o, on_openload_flag_o, led_openload_select_o;
  logic thermal_prewarning_flag_o, undervoltage_flag_o, sense_mirror_en_o, sense_temp_en_o, sense_ratio_select_o;
  logic [1:0] sense_channel_select_o; // routed output
  logic [15:0] rx; // last word read back
  int fails = 0;
  int check_count = 0;
  sscr_core #(.LED_CHECK_CYCLES(20)) sscr_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_n_o(so_oe_n), .rst_pin_n_i(rst_pin_n_i),
    .vdd_fail_i(vdd_fail_i), .por_i(por_i), .vpwr_uv_i(vpwr_uv_i), .clamp_trip_i(clamp_trip_i), .otw_cmp_i(otw_cmp_i),
    .overload_i(overload_i), .dir_in_i(dir_in_i), .ol_cmp_i(ol_cmp_i), .switch_outputs_o(switch_outputs_o),
    .on_openload_flag_o(on_openload_flag_o), .thermal_prewarning_flag_o(thermal_prewarning_flag_o),
    .undervoltage_flag_o(undervoltage_flag_o), .led_openload_select_o(led_openload_select_o),
    .sense_mirror_en_o(sense_mirror_en_o), .sense_temp_en_o(sense_temp_en_o),
    .sense_channel_select_o(sense_channel_select_o), .sense_ratio_select_o(sense_ratio_select_o));
  sscr_host_model sscr_host_model_i (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  ////////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // one sixteen-bit command, readback kept in rx
  task automatic wr(input logic [1:0] o, input logic [2:0] a, input logic [8:0] p);
    sscr_host_model_i.xfer({16'h0, 1'b0, o, a, 1'b0, p}, 16);
    rx = sscr_host_model_i.rx_q[15:0];
  endtask
  // let asynchronous levels cross the synchroniser
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    conclude();
  end
  // main sequence
  initial begin
    sys_rst_i = 1'b1; rst_pin_n_i = 1'b1; vdd_fail_i = 1'b0; por_i = 1'b0;
    clamp_trip_i = 1'b0; otw_cmp_i = 1'b0; dir_in_i = 4'h0; ol_cmp_i = 4'h0; rx = '0;
    vpwr_uv_i = 1'b0; overload_i = 4'h0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle();
    `CHK({switch_outputs_o, on_openload_flag_o, led_openload_select_o, sense_temp_en_o, so_oe_n}, 14'h0001)
    fork wr(2'h2, ADR_DUTY, 9'h080); begin repeat (120) @(posedge clk_i); `CHK(switch_outputs_o, 4'h0) end join
    `CHK(sscr_host_model_i.cs_n_o, 1'b1)
    `CHK(switch_outputs_o, 4'h4)
    @(posedge clk_i) dir_in_i <= 4'h4;
    wr(2'h2, ADR_DUTY, 9'h000);
    `CHK(switch_outputs_o, 4'h4)
    wr(2'h2, ADR_SWC, 9'h020);
    `CHK(switch_outputs_o, 4'h0)
    sscr_host_model_i.xfer({17'h0, 2'h1, ADR_DUTY, 1'b0, 9'h080}, 15);
    settle();
    `CHK(switch_outputs_o, 4'h0)
    fork sscr_host_model_i.xfer({1'b0, 2'h3, ADR_DUTY, 10'h080, 1'b0, 2'h1, ADR_DUTY, 10'h080}, 32);
      begin repeat (120) @(posedge clk_i); `CHK(so_oe_n, 1'b0) end join
    `CHK(switch_outputs_o, 4'h2)
    wr(2'h0, ADR_STAT, 9'h009);
    wr(2'h0, ADR_STAT, 9'h000);
    `CHK(rx[14:0], {2'h1, ADR_DUTY, 1'b0, 9'h080})
    wr(2'h1, ADR_FLT, 9'h008);
    @(posedge clk_i) ol_cmp_i <= 4'h2;
    settle();
    `CHK(on_openload_flag_o, 4'h0)
    wr(2'h1, ADR_FLT, 9'h000);
    `CHK({on_openload_flag_o, switch_outputs_o}, 8'h22)
    @(posedge clk_i) ol_cmp_i <= 4'h0;
    wr(2'h0, ADR_STAT, 9'h000);
    `CHK({rx[3:0], on_openload_flag_o}, 8'h20)
    @(posedge clk_i) otw_cmp_i <= 1'b1;
    settle();
    @(posedge clk_i) otw_cmp_i <= 1'b0;
    settle();
    `CHK(thermal_prewarning_flag_o, 1'b1)
    wr(2'h0, ADR_CAL, 9'h15A);
    `CHK({rx[8:7], thermal_prewarning_flag_o}, 3'b010)
    wr(2'h0, ADR_CAL, CAL_PATTERN);
    wr(2'h0, ADR_STAT, 9'h000);
    `CHK(rx[8:7], 2'b10)
    wr(2'h2, ADR_FLT, 9'h001);
    wr(2'h0, ADR_GCR, 9'h038);
    `CHK({sense_temp_en_o, sense_channel_select_o, sense_ratio_select_o}, 4'b1101)
    @(posedge clk_i) vpwr_uv_i <= 1'b1;
    settle();
    `CHK({undervoltage_flag_o, switch_outputs_o}, 5'h10)
    @(posedge clk_i) vpwr_uv_i <= 1'b0;
    settle();
    `CHK({switch_outputs_o, sense_temp_en_o}, 5'h05)
    @(posedge clk_i) begin vdd_fail_i <= 1'b1; dir_in_i <= 4'h9; end
    settle();
    `CHK({switch_outputs_o, sense_mirror_en_o}, 5'h12)
    @(posedge clk_i) begin vdd_fail_i <= 1'b0; dir_in_i <= 4'h0; end
    settle();
    `CHK(sense_temp_en_o, 1'b1)
    wr(2'h0, ADR_GCR, 9'h138);
    `CHK({rx[6], undervoltage_flag_o}, 2'b10)
    @(posedge clk_i) vdd_fail_i <= 1'b1;
    settle();
    @(posedge clk_i) vdd_fail_i <= 1'b0;
    settle();
    `CHK({sense_temp_en_o, switch_outputs_o}, 5'h00)
    @(posedge clk_i) begin clamp_trip_i <= 1'b1; overload_i <= 4'hF; end
    settle();
    `CHK(switch_outputs_o, 4'hF)
    @(posedge clk_i) begin clamp_trip_i <= 1'b0; overload_i <= 4'h0; end
    wr(2'h3, ADR_FLT, 9'h002);
    `CHK(led_openload_select_o, 4'h8)
    wr(2'h3, ADR_DUTY, 9'h0FF);
    wr(2'h0, ADR_GCR, 9'h080);
    @(posedge clk_i) ol_cmp_i <= 4'h8;
    repeat (70) @(posedge clk_i);
    `CHK(on_openload_flag_o[3], 1'b1)
    @(posedge clk_i) rst_pin_n_i <= 1'b0;
    settle();
    @(posedge clk_i) rst_pin_n_i <= 1'b1;
    @(posedge clk_i) ol_cmp_i <= 4'h0;
    settle();
    `CHK({switch_outputs_o, led_openload_select_o}, 8'h00)
    wr(2'h3, ADR_FLT, 9'h002);
    @(posedge clk_i) por_i <= 1'b1;
    settle();
    @(posedge clk_i) por_i <= 1'b0;
    settle();
    `CHK({led_openload_select_o, on_openload_flag_o}, 8'h00)
    conclude();
  end
endmodule
